// File: rtl/prsd_pkg.sv
// Constants for the power-up clock ratio strap decoder
package prsd_pkg;
	// Register byte offsets
	localparam logic [7:0] PRSD_OFS_STATUS = 8'h00;
	localparam logic [7:0] PRSD_OFS_RATIO = 8'h04;
	localparam logic [7:0] PRSD_OFS_REF_KHZ = 8'h08;
	localparam logic [7:0] PRSD_OFS_PLAT_KHZ = 8'h0c;
	localparam logic [7:0] PRSD_OFS_MEMBUS_KHZ = 8'h10;
	localparam logic [7:0] PRSD_OFS_CORE_KHZ = 8'h14;
	localparam logic [7:0] PRSD_ADDR_MASK = 8'hfc;
	// Status field positions
	localparam int PRSD_ST_PLAT_CODE = 0;
	localparam int PRSD_ST_CORE_CODE = 4;
	localparam int PRSD_ST_PLAT_RSVD = 8;
	localparam int PRSD_ST_CORE_RSVD = 9;
	localparam int PRSD_ST_INVALID = 10;
	localparam int PRSD_ST_SAMPLED = 11;
	// Ratio field positions
	localparam int PRSD_RT_PLAT_MULT = 0;
	localparam int PRSD_RT_CORE_X2 = 8;
	// Reset values
	localparam logic [19:0] PRSD_REF_KHZ_RST = 20'h00000;
	localparam logic [31:0] PRSD_RDATA_RST = 32'h00000000;
	// Platform to reference multiplier per strap code; zero marks reserved
	localparam logic [4:0] PRSD_PLAT_MULT [16] = '{
		5'h10, 5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00,
		5'h08, 5'h09, 5'h0a, 5'h00, 5'h0c, 5'h14, 5'h00, 5'h00};
	// Core to platform ratio in halves per strap code; zero marks reserved
	localparam logic [3:0] PRSD_CORE_X2 [8] = '{
		4'h8, 4'h9, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
endpackage

// File: rtl/prsd_ratio_if.sv
// Strap codes and their decoded ratios between top and decoder
`timescale 1ns/1ps
`default_nettype none
interface prsd_ratio_if;
	logic [3:0] plat_code;
	logic [2:0] core_code;
	logic [4:0] plat_mult;
	logic [3:0] core_x2;
	logic plat_rsvd;
	logic core_rsvd;
	modport decoder (input plat_code, input core_code, output plat_mult, output core_x2,
		output plat_rsvd, output core_rsvd);
	modport user (output plat_code, output core_code, input plat_mult, input core_x2,
		input plat_rsvd, input core_rsvd);
endinterface
`default_nettype wire

// File: rtl/prsd_ratio_decoder.sv
// Table decode of both ratio strap codes
`timescale 1ns/1ps
`default_nettype none
module prsd_ratio_decoder (
	prsd_ratio_if.decoder rif
);
	import prsd_pkg::*;

	always_comb begin
		rif.plat_mult = PRSD_PLAT_MULT[rif.plat_code];
		rif.core_x2 = PRSD_CORE_X2[rif.core_code];
		rif.plat_rsvd = (PRSD_PLAT_MULT[rif.plat_code] == 5'h00);
		rif.core_rsvd = (PRSD_CORE_X2[rif.core_code] == 4'h0);
	end
endmodule // prsd_ratio_decoder
`default_nettype wire

// File: rtl/prsd_strap_top.sv
// Power-up ratio strap sampler and decoder with AHB-Lite status registers
`timescale 1ns/1ps
`default_nettype none
module prsd_strap_top (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Configuration straps
	input wire logic [3:0] platform_ratio_strap,
	input wire logic core_ratio_strap_msb,
	input wire logic core_ratio_strap_mid,
	input wire logic core_ratio_strap_lsb,
	// Decoded configuration
	output logic straps_sampled,
	output logic config_invalid,
	output logic [4:0] platform_mult,
	output logic [3:0] core_ratio_x2
);
	import prsd_pkg::*;

	prsd_ratio_if rif ();

	logic sampled_q;
	logic [3:0] plat_code_q;
	logic [2:0] core_code_q;
	logic [19:0] ref_khz_q;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] plat_khz;
	logic [31:0] membus_khz;
	logic [31:0] core_khz;
	logic [31:0] status_word;
	logic [31:0] ratio_word;
	logic [31:0] rdata_d;
	logic addr_phase;

	assign rif.plat_code = plat_code_q;
	assign rif.core_code = core_code_q;

	prsd_ratio_decoder u_dec (
		.rif(rif)
	);

	// Straps are caught once, on the first edge after reset release
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sampled_q <= 1'b0;
			plat_code_q <= 4'h0;
			core_code_q <= 3'h0;
		end else if (!sampled_q) begin
			sampled_q <= 1'b1;
			plat_code_q <= platform_ratio_strap;
			core_code_q <= {core_ratio_strap_msb, core_ratio_strap_mid, core_ratio_strap_lsb};
		end
	end

	// Decoded outputs stay zero until a strap value exists
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			straps_sampled <= 1'b0;
			config_invalid <= 1'b0;
			platform_mult <= 5'h00;
			core_ratio_x2 <= 4'h0;
		end else begin
			straps_sampled <= sampled_q;
			config_invalid <= sampled_q && (rif.plat_rsvd || rif.core_rsvd);
			platform_mult <= sampled_q ? rif.plat_mult : 5'h00;
			core_ratio_x2 <= sampled_q ? rif.core_x2 : 4'h0;
		end
	end

	// One clock feeds platform bus and memory rate math
	assign plat_khz = 32'(ref_khz_q) * 32'(platform_mult);
	assign membus_khz = {1'b0, plat_khz[31:1]};
	assign core_khz = 32'((plat_khz * 32'(core_ratio_x2)) >> 1);

	always_comb begin
		status_word = 32'h00000000;
		status_word[PRSD_ST_PLAT_CODE +: 4] = plat_code_q;
		status_word[PRSD_ST_CORE_CODE +: 3] = core_code_q;
		status_word[PRSD_ST_PLAT_RSVD] = straps_sampled && rif.plat_rsvd;
		status_word[PRSD_ST_CORE_RSVD] = straps_sampled && rif.core_rsvd;
		status_word[PRSD_ST_INVALID] = config_invalid;
		status_word[PRSD_ST_SAMPLED] = straps_sampled;
		ratio_word = 32'h00000000;
		ratio_word[PRSD_RT_PLAT_MULT +: 5] = platform_mult;
		ratio_word[PRSD_RT_CORE_X2 +: 4] = core_ratio_x2;
	end

	// Bus: zero wait states, read data prepared at the address phase
	assign addr_phase = hsel && hready && htrans[1];

	always_comb begin
		unique case (haddr[7:0] & PRSD_ADDR_MASK)
			PRSD_OFS_STATUS: rdata_d = status_word;
			PRSD_OFS_RATIO: rdata_d = ratio_word;
			PRSD_OFS_REF_KHZ: rdata_d = {12'h000, ref_khz_q};
			PRSD_OFS_PLAT_KHZ: rdata_d = plat_khz;
			PRSD_OFS_MEMBUS_KHZ: rdata_d = membus_khz;
			PRSD_OFS_CORE_KHZ: rdata_d = core_khz;
			default: rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= PRSD_RDATA_RST;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addr_phase && !hwrite) begin
				hrdata <= rdata_d;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= addr_phase && hwrite;
			if (addr_phase) begin
				wr_addr_q <= haddr[7:0] & PRSD_ADDR_MASK;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ref_khz_q <= PRSD_REF_KHZ_RST;
		end else if (wr_pend_q && wr_addr_q == PRSD_OFS_REF_KHZ) begin
			ref_khz_q <= hwdata[19:0];
		end
	end

	// Checks
	strap_capture_a: assert property (@(posedge clk) disable iff (reset)
		$rose(sampled_q) |-> plat_code_q == $past(platform_ratio_strap))
		else $error("Platform strap not captured at first edge");
	core_capture_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q |=> $stable(core_code_q) && $stable(plat_code_q))
		else $error("Strap code changed after sampling");
	plat_low_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && plat_code_q == 4'h0 |=> platform_mult == 5'h10)
		else $error("Platform code 0000 not 16 times");
	plat_high_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && plat_code_q == 4'hd |=> platform_mult == 5'h14 && config_invalid == (core_code_q == 3'h2))
		else $error("Platform code 1101 not 20 times");
	plat_reserved_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && plat_code_q inside {4'h1, 4'h7, 4'hb, 4'he, 4'hf} |=> config_invalid && platform_mult == 5'h00)
		else $error("Reserved platform code not flagged");
	no_default_a: assert property (@(posedge clk) disable iff (reset)
		!straps_sampled |-> platform_mult == 5'h00 && !config_invalid)
		else $error("Ratio present before strap sampling");
	core_ratio_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && core_code_q == 3'h1 |=> core_ratio_x2 == 4'h9)
		else $error("Core code 001 not 9:2");
	core_reserved_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && core_code_q == 3'h2 |=> config_invalid && core_ratio_x2 == 4'h0)
		else $error("Core code 010 not flagged");
	core_top_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && core_code_q == 3'h7 |=> core_ratio_x2 == 4'h7)
		else $error("Core code 111 not 7:2");
	membus_half_a: assert property (@(posedge clk) disable iff (reset)
		addr_phase && !hwrite && (haddr[7:0] & PRSD_ADDR_MASK) == PRSD_OFS_MEMBUS_KHZ
		|=> hrdata == ($past(ref_khz_q) * $past(platform_mult)) / 2)
		else $error("Memory bus rate not half platform");
	plat_freq_a: assert property (@(posedge clk) disable iff (reset)
		addr_phase && !hwrite && (haddr[7:0] & PRSD_ADDR_MASK) == PRSD_OFS_PLAT_KHZ
		|=> hrdata == $past(ref_khz_q) * $past(platform_mult))
		else $error("Platform rate not reference times multiplier");

	// One check per valid platform code
	plat_x2_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && plat_code_q == 4'h2
		|=> platform_mult == 5'h02)
		else $error("Platform code 0010 not 2 times");
	plat_x3_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && plat_code_q == 4'h3
		|=> platform_mult == 5'h03)
		else $error("Platform code 0011 not 3 times");
	plat_x4_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && plat_code_q == 4'h4
		|=> platform_mult == 5'h04)
		else $error("Platform code 0100 not 4 times");
	plat_x5_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && plat_code_q == 4'h5
		|=> platform_mult == 5'h05)
		else $error("Platform code 0101 not 5 times");
	plat_x6_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && plat_code_q == 4'h6
		|=> platform_mult == 5'h06)
		else $error("Platform code 0110 not 6 times");
	plat_x8_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && plat_code_q == 4'h8
		|=> platform_mult == 5'h08)
		else $error("Platform code 1000 not 8 times");
	plat_x9_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && plat_code_q == 4'h9
		|=> platform_mult == 5'h09)
		else $error("Platform code 1001 not 9 times");
	plat_x10_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && plat_code_q == 4'ha
		|=> platform_mult == 5'h0a)
		else $error("Platform code 1010 not 10 times");
	plat_x12_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && plat_code_q == 4'hc
		|=> platform_mult == 5'h0c)
		else $error("Platform code 1100 not 12 times");
	plat_valid_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && !(plat_code_q inside {4'h1, 4'h7, 4'hb, 4'he, 4'hf})
		|=> platform_mult != 5'h00)
		else $error("Valid platform code gave no multiplier");

	// One check per valid core code
	core_x4_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && core_code_q == 3'h0
		|=> core_ratio_x2 == 4'h8)
		else $error("Core code 000 not 4:1");
	core_x3h_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && core_code_q == 3'h3
		|=> core_ratio_x2 == 4'h3)
		else $error("Core code 011 not 3:2");
	core_x2_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && core_code_q == 3'h4
		|=> core_ratio_x2 == 4'h4)
		else $error("Core code 100 not 2:1");
	core_x5h_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && core_code_q == 3'h5
		|=> core_ratio_x2 == 4'h5)
		else $error("Core code 101 not 5:2");
	core_x3_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && core_code_q == 3'h6
		|=> core_ratio_x2 == 4'h6)
		else $error("Core code 110 not 3:1");
	core_valid_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q && core_code_q != 3'h2
		|=> core_ratio_x2 != 4'h0)
		else $error("Valid core code gave no ratio");

	// Flags and register reads
	invalid_exact_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q
		|=> config_invalid == ($past(plat_code_q) inside {4'h1, 4'h7, 4'hb, 4'he, 4'hf}
		|| $past(core_code_q) == 3'h2))
		else $error("Invalid flag disagrees with sampled codes");
	sampled_level_a: assert property (@(posedge clk) disable iff (reset)
		sampled_q |=> straps_sampled)
		else $error("Sampled indication missing after capture");
	ref_write_a: assert property (@(posedge clk) disable iff (reset)
		wr_pend_q && wr_addr_q == PRSD_OFS_REF_KHZ
		|=> ref_khz_q == $past(hwdata[19:0]))
		else $error("Reference rate write lost");
	ref_read_a: assert property (@(posedge clk) disable iff (reset)
		addr_phase && !hwrite && (haddr[7:0] & PRSD_ADDR_MASK) == PRSD_OFS_REF_KHZ
		|=> hrdata == {12'h000, $past(ref_khz_q)})
		else $error("Reference rate read wrong");
	core_freq_a: assert property (@(posedge clk) disable iff (reset)
		addr_phase && !hwrite && (haddr[7:0] & PRSD_ADDR_MASK) == PRSD_OFS_CORE_KHZ
		|=> hrdata == ($past(ref_khz_q) * $past(platform_mult) * $past(core_ratio_x2)) / 2)
		else $error("Core rate not platform times core ratio");
	ratio_read_a: assert property (@(posedge clk) disable iff (reset)
		addr_phase && !hwrite && (haddr[7:0] & PRSD_ADDR_MASK) == PRSD_OFS_RATIO
		|=> hrdata[4:0] == $past(platform_mult) && hrdata[11:8] == $past(core_ratio_x2))
		else $error("Ratio register disagrees with outputs");
	status_read_a: assert property (@(posedge clk) disable iff (reset)
		addr_phase && !hwrite && (haddr[7:0] & PRSD_ADDR_MASK) == PRSD_OFS_STATUS
		|=> hrdata[10] == $past(config_invalid) && hrdata[11] == $past(straps_sampled))
		else $error("Status register disagrees with flags");
	status_code_a: assert property (@(posedge clk) disable iff (reset)
		addr_phase && !hwrite && (haddr[7:0] & PRSD_ADDR_MASK) == PRSD_OFS_STATUS
		|=> hrdata[3:0] == $past(plat_code_q) && hrdata[6:4] == $past(core_code_q))
		else $error("Status register disagrees with strap codes");
endmodule // prsd_strap_top
`default_nettype wire

// File: sim/prsd_strap_board.sv
// Board pull resistors that hold the ratio straps at a chosen setting
`timescale 1ns/1ps
`default_nettype none
module prsd_strap_board (
	// Chosen board setting
	input wire logic [3:0] plat_sel,
	input wire logic [2:0] core_sel,
	// Strap lines, always pulled to a level
	output logic [3:0] platform_ratio_strap,
	output logic [2:0] core_strap
);
	assign platform_ratio_strap = plat_sel;
	assign core_strap = core_sel;
endmodule // prsd_strap_board
`default_nettype wire

// File: sim/pll_ratio_strap_decoder_tb_top.sv
// Self-checking bench for the ratio strap decoder
`timescale 1ns/1ps
`default_nettype none
module pll_ratio_strap_decoder_tb_top;
	import prsd_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, straps_sampled, config_invalid;
	logic [31:0] hrdata;
	logic [4:0] platform_mult;
	logic [3:0] core_ratio_x2;
	logic [3:0] plat_sel = 4'h0;
	logic [2:0] core_sel = 3'h0;
	logic [3:0] platform_ratio_strap;
	logic [2:0] core_strap;
	int n_mismatch = 0;
	int total_checks = 0;
	// Expected ratios, zero where the code is reserved
	logic [4:0] pt [16] = '{5'h10, 5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h00,
		5'h08, 5'h09, 5'h0a, 5'h00, 5'h0c, 5'h14, 5'h00, 5'h00};
	logic [3:0] ct [8] = '{4'h8, 4'h9, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
	always #12.5 clk = ~clk;
	prsd_strap_board board_u (.plat_sel(plat_sel), .core_sel(core_sel),
		.platform_ratio_strap(platform_ratio_strap), .core_strap(core_strap));
	prsd_strap_top dut_u (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .platform_ratio_strap(platform_ratio_strap),
		.core_ratio_strap_msb(core_strap[2]), .core_ratio_strap_mid(core_strap[1]),
		.core_ratio_strap_lsb(core_strap[0]), .straps_sampled(straps_sampled),
		.config_invalid(config_invalid), .platform_mult(platform_mult), .core_ratio_x2(core_ratio_x2));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Waits for hready at a rising edge, bounded
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			n_mismatch++;
			end_of_test();
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
		check(hresp, 1'b0);
	endtask
	task automatic do_reset(input logic [3:0] p, input logic [2:0] c);
		plat_sel <= p;
		core_sel <= c;
		reset <= 1'b1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// Every code of both straps, each after its own power-up reset
	task automatic test_decode();
		logic [31:0] rd;
		logic prsv, crsv;
		for (int i = 0; i < 16; i++) begin
			do_reset(i[3:0], i[2:0]);
			prsv = (pt[i] == 5'h00);
			crsv = (ct[i % 8] == 4'h0);
			check(straps_sampled, 1'b1);
			check(platform_mult, pt[i]);
			check(core_ratio_x2, ct[i % 8]);
			check(config_invalid, prsv | crsv);
			ahb(1'b0, PRSD_OFS_STATUS, 32'h0, rd);
			check(rd, {20'h0, 1'b1, prsv | crsv, crsv, prsv, 1'b0, i[2:0], i[3:0]});
			plat_sel <= ~i[3:0];
			core_sel <= ~i[2:0];
			ahb(1'b0, PRSD_OFS_RATIO, 32'h0, rd);
			check(rd, {20'h0, ct[i % 8], 3'h0, pt[i]});
		end
	endtask
	// Frequencies from a written reference, plus ignored writes
	task automatic test_freq(input logic [3:0] p, input logic [2:0] c, input logic [19:0] rk);
		logic [31:0] rd, pk;
		do_reset(p, c);
		pk = rk * pt[p];
		ahb(1'b1, PRSD_OFS_REF_KHZ, {12'hfff, rk}, rd);
		ahb(1'b1, PRSD_OFS_PLAT_KHZ, 32'h0, rd);
		ahb(1'b0, PRSD_OFS_REF_KHZ, 32'h0, rd);
		check(rd, {12'h0, rk});
		ahb(1'b0, PRSD_OFS_PLAT_KHZ, 32'h0, rd);
		check(rd, pk);
		check(rd >= 32'd333000, 1'b1);
		ahb(1'b0, PRSD_OFS_MEMBUS_KHZ, 32'h0, rd);
		check(rd, pk / 2);
		check(rd >= 32'd166000 && rd <= 32'd200000, 1'b1);
		ahb(1'b0, PRSD_OFS_CORE_KHZ, 32'h0, rd);
		check(rd, (pk * ct[c]) / 2);
		check(rd >= 32'd800000 && rd <= 32'd1333000, 1'b1);
		ahb(1'b1, 8'h20, 32'h1234, rd);
		ahb(1'b0, 8'h20, 32'h0, rd);
		check(rd, 32'h0);
	endtask
	initial begin
		#125000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		test_decode();
		test_freq(4'h4, 3'h6, 20'd100000);
		test_freq(4'h9, 3'h7, 20'd41667);
		end_of_test();
	end
endmodule // pll_ratio_strap_decoder_tb_top
`default_nettype wire
